// [shared/sac_cfg.svh]
// Functional notes
// - Data sampled on serial clock rising edge
// - Shifting only while frame strobe low
// - Frame: select byte then attenuation byte
// - Both bytes sent most significant first
// - Select 00/01/02 picks channel 1/2/3
// - Codes 7f and above mute the channel
// - All channels muted by reset
// - Strobe rise latches, decodes, applies frame
// - Only addressed channel changes its setting
// - Data output shows previously held bits
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// =====================================================================
// Frame layout
`define SAC_FRAME_BITS 16
`define SAC_SEL_MSB 15
`define SAC_SEL_LSB 8
`define SAC_CODE_MSB 7
`define SAC_CODE_LSB 0
`define SAC_NUM_CHANNELS 3

// =====================================================================
// Channel select values
`define SAC_SEL_CH1 8'h00
`define SAC_SEL_CH2 8'h01
`define SAC_SEL_CH3 8'h02

// =====================================================================
// Attenuation code ranges, in half-dB units
`define SAC_CODE_FINE_MAX 8'h5f
`define SAC_CODE_COARSE_BASE 8'h60
`define SAC_CODE_COARSE_MAX 8'h7e
`define SAC_CODE_MUTE_MIN 8'h7f
`define SAC_MUTE_HALF_DB 8'hc8

// =====================================================================
// Reset values
`define SAC_RESET_CODE 8'h7f
`define SAC_RESET_FRAME 16'h0000

// =====================================================================
// Timing
`define SAC_CLK_PERIOD_PS 4000
`define SAC_STROBE_SETUP_NS 150
`define SAC_STROBE_SETUP_CYCLES \
    ((`SAC_STROBE_SETUP_NS * 1000 + `SAC_CLK_PERIOD_PS - 1) / `SAC_CLK_PERIOD_PS)

`endif

// [shared/sac_pkg.sv]
`include "sac_cfg.svh"

package sac_pkg;

    typedef logic [7:0] sac_byte_type;

    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_APPLY
    } sac_phase_type;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } sac_sync_state_type;

    typedef struct packed {
        logic [`SAC_FRAME_BITS-1:0] shift;
    } sac_link_state_type;

    typedef struct packed {
        sac_phase_type phase;
        logic strobe_prev;
        logic [`SAC_FRAME_BITS-1:0] frame;
        logic [`SAC_NUM_CHANNELS-1:0][7:0] tap_code;
        logic [`SAC_NUM_CHANNELS-1:0] mute;
        logic [`SAC_NUM_CHANNELS-1:0][7:0] half_db;
        logic applied;
        logic bad_select;
        logic [15:0] frame_count;
    } sac_ctrl_state_type;

endpackage : sac_pkg

// [hdl/sac_sync.sv]
`timescale 1ns/1ps

// =====================================================================
// Two-stage level synchroniser
module sac_sync (
    input wire logic clk,
    input wire logic async_in,
    output logic sync_out
);

    sac_pkg::sac_sync_state_type r;
    sac_pkg::sac_sync_state_type next_r;

    always_comb begin
        next_r = r;
        next_r.stage1 = async_in;
        next_r.stage2 = r.stage1;
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign sync_out = r.stage2;

endmodule : sac_sync

// [hdl/sac_link_shift.sv]
`timescale 1ns/1ps
`include "sac_cfg.svh"

// =====================================================================
// Serial-clock domain shift register
module sac_link_shift (
    input wire logic sclk,
    input wire logic link_rst,
    input wire logic frame_strobe_n,
    input wire logic serial_data_in,
    output logic [`SAC_FRAME_BITS-1:0] shift_word,
    output logic serial_data_out
);

    sac_pkg::sac_link_state_type r;
    sac_pkg::sac_link_state_type next_r;

    always_comb begin
        next_r = r;
        if (link_rst) begin
            next_r.shift = `SAC_RESET_FRAME;
        end else if (!frame_strobe_n) begin
            next_r.shift = {r.shift[`SAC_FRAME_BITS-2:0], serial_data_in};
        end
    end

    always_ff @(posedge sclk) begin
        r <= next_r;
    end

    assign shift_word = r.shift;
    assign serial_data_out = r.shift[`SAC_FRAME_BITS-1];

    // =================================================================
    // Checks
    chk_shift_hold: assert property (@(posedge sclk) disable iff (link_rst)
        frame_strobe_n |=> $stable(shift_word))
        else $error("shift register moved while strobe high");

    chk_shift_in: assert property (@(posedge sclk) disable iff (link_rst)
        !frame_strobe_n |=> shift_word[0] == $past(serial_data_in)
            && shift_word[15:1] == $past(shift_word[14:0]))
        else $error("serial bit not shifted in msb first");

    chk_data_out: assert property (@(posedge sclk) disable iff (link_rst)
        !frame_strobe_n |=> serial_data_out == $past(shift_word[14]))
        else $error("chain output not the previously held bit");

endmodule : sac_link_shift

// [hdl/sac_top.sv]
`timescale 1ns/1ps
`include "sac_cfg.svh"

// =====================================================================
// Serial attenuator control: link capture and channel settings
module sac_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic frame_strobe_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic [`SAC_NUM_CHANNELS-1:0][7:0] chan_tap_code,
    output logic [`SAC_NUM_CHANNELS-1:0] chan_mute,
    output logic [`SAC_NUM_CHANNELS-1:0][7:0] chan_half_db,
    output logic frame_applied,
    output logic select_error,
    output logic [15:0] frame_count
);

    // =================================================================
    // Decode helpers
    function automatic logic sel_valid(input logic [7:0] sel);
        sel_valid = (sel == `SAC_SEL_CH1) || (sel == `SAC_SEL_CH2)
            || (sel == `SAC_SEL_CH3);
    endfunction : sel_valid

    function automatic logic [1:0] sel_index(input logic [7:0] sel);
        sel_index = sel[1:0];
    endfunction : sel_index

    function automatic logic code_is_mute(input logic [7:0] code);
        code_is_mute = (code >= `SAC_CODE_MUTE_MIN);
    endfunction : code_is_mute

    function automatic logic [7:0] code_half_db(input logic [7:0] code);
        logic [7:0] steps;
        steps = 8'h00;
        if (code <= `SAC_CODE_FINE_MAX) begin
            code_half_db = code;
        end else if (code <= `SAC_CODE_COARSE_MAX) begin
            steps = 8'(code - `SAC_CODE_COARSE_BASE);
            code_half_db = 8'(`SAC_CODE_COARSE_BASE + {steps[6:0], 1'b0});
        end else begin
            code_half_db = `SAC_MUTE_HALF_DB;
        end
    endfunction : code_half_db

    // =================================================================
    // Clock domain crossings
    logic link_rst;
    logic strobe_sync;
    logic [`SAC_FRAME_BITS-1:0] shift_word;

    sac_sync u_rst_sync (
        .clk(sclk),
        .async_in(srst),
        .sync_out(link_rst)
    );

    sac_sync u_strobe_sync (
        .clk(clk),
        .async_in(frame_strobe_n),
        .sync_out(strobe_sync)
    );

    // =================================================================
    // Link side shift register
    sac_link_shift u_link (
        .sclk(sclk),
        .link_rst(link_rst),
        .frame_strobe_n(frame_strobe_n),
        .serial_data_in(serial_data_in),
        .shift_word(shift_word),
        .serial_data_out(serial_data_out)
    );

    // =================================================================
    // Control state
    sac_pkg::sac_ctrl_state_type r;
    sac_pkg::sac_ctrl_state_type next_r;

    logic strobe_rise;
    logic [7:0] frame_sel;
    logic [7:0] frame_code;
    logic [1:0] frame_idx;

    assign strobe_rise = strobe_sync && !r.strobe_prev;
    assign frame_sel = r.frame[`SAC_SEL_MSB:`SAC_SEL_LSB];
    assign frame_code = r.frame[`SAC_CODE_MSB:`SAC_CODE_LSB];
    assign frame_idx = sel_index(frame_sel);

    always_comb begin
        next_r = r;
        next_r.strobe_prev = strobe_sync;
        next_r.applied = 1'b0;
        next_r.bad_select = 1'b0;
        if (srst) begin
            next_r.phase = sac_pkg::SAC_IDLE;
            next_r.strobe_prev = 1'b1;
            next_r.frame = `SAC_RESET_FRAME;
            for (int i = 0; i < `SAC_NUM_CHANNELS; i++) begin
                next_r.tap_code[i] = `SAC_RESET_CODE;
                next_r.mute[i] = 1'b1;
                next_r.half_db[i] = `SAC_MUTE_HALF_DB;
            end
            next_r.frame_count = 16'h0000;
        end else begin
            case (r.phase)
                sac_pkg::SAC_IDLE: begin
                    if (strobe_rise) begin
                        next_r.frame = shift_word;
                        next_r.phase = sac_pkg::SAC_APPLY;
                    end
                end
                sac_pkg::SAC_APPLY: begin
                    next_r.phase = sac_pkg::SAC_IDLE;
                    next_r.applied = 1'b1;
                    next_r.frame_count = 16'(r.frame_count + 16'h0001);
                    if (sel_valid(frame_sel)) begin
                        next_r.tap_code[frame_idx] = frame_code;
                        next_r.mute[frame_idx] = code_is_mute(frame_code);
                        next_r.half_db[frame_idx] = code_half_db(frame_code);
                    end else begin
                        next_r.bad_select = 1'b1;
                    end
                end
                default: begin
                    next_r.phase = sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    // =================================================================
    // Outputs
    assign chan_tap_code = r.tap_code;
    assign chan_mute = r.mute;
    assign chan_half_db = r.half_db;
    assign frame_applied = r.applied;
    assign select_error = r.bad_select;
    assign frame_count = r.frame_count;

    // =================================================================
    // Checks
    logic apply_now;
    logic apply_ok;
    assign apply_now = (r.phase == sac_pkg::SAC_APPLY);
    assign apply_ok = apply_now && sel_valid(frame_sel);

    chk_reset_mute: assert property (@(posedge clk)
        srst |=> (&chan_mute) && chan_half_db[0] == `SAC_MUTE_HALF_DB
            && !frame_applied)
        else $error("channels not muted after reset");

    chk_rise_apply: assert property (@(posedge clk) disable iff (srst)
        (r.phase == sac_pkg::SAC_IDLE) && strobe_rise |=> apply_now
            && r.frame == $past(shift_word) ##1 frame_applied)
        else $error("strobe rise not applied two cycles later");

    chk_fine_step: assert property (@(posedge clk) disable iff (srst)
        apply_ok && frame_code <= `SAC_CODE_FINE_MAX |=>
            chan_half_db[$past(frame_idx)] == $past(frame_code)
            && !chan_mute[$past(frame_idx)])
        else $error("fine step attenuation wrong");

    chk_coarse_step: assert property (@(posedge clk) disable iff (srst)
        apply_ok && frame_code == 8'h61 |=>
            chan_half_db[$past(frame_idx)] == 8'h62)
        else $error("coarse step attenuation wrong");

    chk_coarse_top: assert property (@(posedge clk) disable iff (srst)
        apply_ok && frame_code == `SAC_CODE_COARSE_MAX |=>
            chan_half_db[$past(frame_idx)] == 8'h9c && !chan_mute[$past(frame_idx)])
        else $error("top coarse step not 78 dB");

    chk_mute_code: assert property (@(posedge clk) disable iff (srst)
        apply_ok && frame_code >= `SAC_CODE_MUTE_MIN |=> chan_mute[$past(frame_idx)])
        else $error("mute code did not mute channel");

    chk_idle_hold: assert property (@(posedge clk) disable iff (srst)
        !apply_now |=> $stable(chan_tap_code) && $stable(chan_mute)
            && $stable(chan_half_db))
        else $error("channel changed without a frame");

    chk_bad_select: assert property (@(posedge clk) disable iff (srst)
        apply_now && !sel_valid(frame_sel) |=> select_error
            && $stable(chan_tap_code) && $stable(chan_mute))
        else $error("unknown select changed a channel");

    chk_ch2_only: assert property (@(posedge clk) disable iff (srst)
        apply_now && frame_sel == `SAC_SEL_CH2 |=> $stable(chan_tap_code[0])
            && $stable(chan_tap_code[2]) && chan_tap_code[1] == $past(frame_code))
        else $error("channel two select hit wrong channel");

    cov_frame_applied: cover property (@(posedge clk) disable iff (srst)
        frame_applied);
    cov_mute_frame: cover property (@(posedge clk) disable iff (srst)
        apply_ok && code_is_mute(frame_code));
    cov_ch3_frame: cover property (@(posedge clk) disable iff (srst)
        apply_now && frame_sel == `SAC_SEL_CH3);
    cov_bad_select: cover property (@(posedge clk) disable iff (srst)
        select_error);

endmodule : sac_top

// [verification/sac_host_model.sv]
`timescale 1ns/1ps

// =====================================================================
// Host side of the serial link
module sac_host_model (
    output logic sclk,
    output logic frame_strobe_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    logic [31:0] seen;

    initial begin
        sclk = 1'b0;
        frame_strobe_n = 1'b1;
        serial_data_in = 1'b0;
        seen = 32'h0;
    end

    // Frame of n bits, most significant first
    task automatic send_bits(input logic [31:0] bits, input int n);
        frame_strobe_n = 1'b0;
        #150;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in = bits[i];
            #16;
            seen = {seen[30:0], serial_data_out};
            sclk = 1'b1;
            #16;
            sclk = 1'b0;
        end
        frame_strobe_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #100;
    endtask : send_bits

    // Clock pulses with the strobe high
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            serial_data_in = i[0];
            #16;
            sclk = 1'b1;
            #16;
            sclk = 1'b0;
        end
    endtask : idle_clocks
endmodule : sac_host_model

// [verification/tb.sv]
`timescale 1ns/1ps
`include "sac_cfg.svh"

// =====================================================================
// Testbench
module tb;
    logic clk;
    logic srst;
    wire sclk;
    wire frame_strobe_n;
    wire serial_data_in;
    wire serial_data_out;
    logic [`SAC_NUM_CHANNELS-1:0][7:0] chan_tap_code;
    logic [`SAC_NUM_CHANNELS-1:0] chan_mute;
    logic [`SAC_NUM_CHANNELS-1:0][7:0] chan_half_db;
    logic frame_applied;
    logic select_error;
    logic [15:0] frame_count;
    logic [2:0][7:0] exp_code;
    int err_total;
    int tests_run;
    int cycles;
    int n_applied;
    int n_bad;
    int n_bad_exp;

    sac_top i_sac_top (
        .clk(clk),
        .srst(srst),
        .sclk(sclk),
        .frame_strobe_n(frame_strobe_n),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .chan_tap_code(chan_tap_code),
        .chan_mute(chan_mute),
        .chan_half_db(chan_half_db),
        .frame_applied(frame_applied),
        .select_error(select_error),
        .frame_count(frame_count)
    );

    sac_host_model i_sac_host_model (
        .sclk(sclk),
        .frame_strobe_n(frame_strobe_n),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out)
    );

    always #2 clk = ~clk;

    // =====================================================================
    // Pulse counting and timeout
    always @(posedge clk) begin
        if (frame_applied === 1'b1) n_applied++;
        if (select_error === 1'b1) n_bad++;
        cycles++;
        if (cycles == 10000) begin
            err_total++;
            close_out();
        end
    end

    // =====================================================================
    // Helpers
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val

    function automatic logic [7:0] exp_hdb(input logic [7:0] c);
        if (c <= 8'h5f) return c;
        if (c <= 8'h7e) return 8'h60 + 8'h02 * (c - 8'h60);
        return 8'hc8;
    endfunction : exp_hdb

    task automatic check_chans();
        for (int c = 0; c < 3; c++) begin
            cmp_val({8'h00, chan_tap_code[c]}, {8'h00, exp_code[c]});
            cmp_val({15'h0, chan_mute[c]}, {15'h0, exp_code[c] >= 8'h7f});
            cmp_val({8'h00, chan_half_db[c]}, {8'h00, exp_hdb(exp_code[c])});
        end
    endtask : check_chans

    task automatic send(input logic [31:0] bits, input int n, input logic [7:0] sel,
                        input logic [7:0] code);
        int want;
        want = n_applied + 1;
        i_sac_host_model.send_bits(bits, n);
        for (int i = 0; i < 50 && n_applied != want; i++) @(posedge clk);
        cmp_val(n_applied[15:0], want[15:0]);
        cmp_val(frame_count, want[15:0]);
        if (sel < 8'h03) exp_code[sel[1:0]] = code;
        else n_bad_exp++;
        cmp_val(n_bad[15:0], n_bad_exp[15:0]);
        check_chans();
    endtask : send

    // =====================================================================
    // Scenarios
    task automatic t_reset();
        cmp_val(frame_count, 16'h0000);
        check_chans();
    endtask : t_reset

    task automatic t_codes();
        logic [7:0] codes [9];
        codes = '{8'h00, 8'h01, 8'h5f, 8'h60, 8'h61, 8'h7e, 8'h7f, 8'h80, 8'hff};
        for (int i = 0; i < 9; i++) begin
            send({16'h0, 8'(i % 3), codes[i]}, 16, 8'(i % 3), codes[i]);
        end
    endtask : t_codes

    task automatic t_bad_select();
        send({16'h0, 8'h03, 8'h10}, 16, 8'h03, 8'h10);
        send({16'h0, 8'hff, 8'h00}, 16, 8'hff, 8'h00);
    endtask : t_bad_select

    task automatic t_chain();
        send({16'h0, 8'h00, 8'h22}, 16, 8'h00, 8'h22);
        send({16'h0, 8'h02, 8'h44}, 16, 8'h02, 8'h44);
        cmp_val(i_sac_host_model.seen[15:0], 16'h0022);
    endtask : t_chain

    task automatic t_short();
        send({16'h0, 8'h00, 8'h01}, 16, 8'h00, 8'h01);
        i_sac_host_model.idle_clocks(8);
        send({24'h0, 8'h30}, 8, 8'h01, 8'h30);
        send({8'h00, 24'haa0211}, 24, 8'h02, 8'h11);
    endtask : t_short

    // =====================================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        exp_code = {3{8'h7f}};
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        n_applied = 0;
        n_bad = 0;
        n_bad_exp = 0;
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_codes();
        t_bad_select();
        t_chain();
        t_short();
        close_out();
    end
endmodule : tb
